// [emm_pkg.sv]
// Constants, field layouts and carriers for the port identification manager
package emm_pkg;
  localparam int NIN = 4;
  localparam int NOUT = 4;
  localparam int NSLOT = 4;
  localparam int BLK_BYTES = 128;
  localparam int EDID_BYTES = 2 * BLK_BYTES;
  localparam int PW = 2;
  localparam int BW = 8;
  localparam int MW = PW + BW;
  // Register byte offsets
  localparam logic [7:0] EMU_CFG_OFS = 8'h00;
  localparam logic [7:0] OUT_CFG_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h20;
  localparam logic [7:0] POOL_ADDR_OFS = 8'h24;
  localparam logic [7:0] POOL_DATA_OFS = 8'h28;
  localparam logic [7:0] CAP_ADDR_OFS = 8'h2c;
  localparam logic [7:0] CAP_DATA_OFS = 8'h30;
  localparam logic [3:0] EMU_CFG_RST = 4'h8;
  localparam logic [2:0] OUT_CFG_RST = 3'h0;
  // Status field positions
  localparam int ST_HPD_LSB = 0;
  localparam int ST_VALID_LSB = 4;
  localparam int ST_PEND_LSB = 8;
  localparam int ST_BUSY_BIT = 12;
  // Hot-plug toggle interval
  localparam longint HPD_TIME_MS = 2000;
  localparam longint CLK_KHZ = 40000;
  localparam int HPD_CYCLES = int'(HPD_TIME_MS * CLK_KHZ);
  localparam int HPD_CW = 32;
  typedef struct packed {
    logic hdcp_en;
    logic [PW-1:0] src;
    logic dynamic;
  } emm_emu_cfg_t;
  typedef struct packed {
    logic enc_always;
    logic [PW-1:0] route;
  } emm_out_cfg_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic good;
    logic [PW-1:0] port;
    logic [BW-1:0] addr;
    logic [7:0] data;
  } emm_cap_t;
endpackage : emm_pkg

// [emm_port_manager.sv]
// Identification emulation, sink capture and copy-protection policy per port
`timescale 1ns/1ps

module emm_port_manager #(
  parameter int HPD_CYC = emm_pkg::HPD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire emm_pkg::emm_cap_t cap,
  input wire logic [emm_pkg::NIN*8-1:0] ddc_addr,
  output logic [emm_pkg::NIN*8-1:0] ddc_data,
  output logic [emm_pkg::NIN-1:0] sink_presence_line,
  output logic [emm_pkg::NIN-1:0] hdcp_capable,
  input wire logic [emm_pkg::NIN-1:0] in_encrypted,
  input wire logic [emm_pkg::NIN-1:0] in_protected,
  input wire logic [emm_pkg::NOUT-1:0] sink_hdcp_ok,
  output logic [emm_pkg::NOUT*2-1:0] out_route,
  output logic [emm_pkg::NOUT-1:0] out_encrypt,
  output logic [emm_pkg::NOUT-1:0] out_alert
);

  // ****************************************
  // Storage
  // ****************************************
  function automatic logic [emm_pkg::MW-1:0] mem_idx(
    input logic [emm_pkg::PW-1:0] port,
    input logic [emm_pkg::BW-1:0] byte_no
  );
    mem_idx = {port, byte_no};
  endfunction : mem_idx

  // No reset on these arrays: contents survive sink loss
  logic [7:0] pool_mem [emm_pkg::NSLOT*emm_pkg::EDID_BYTES];
  logic [7:0] out_mem [emm_pkg::NOUT*emm_pkg::EDID_BYTES];
  logic [7:0] in_mem [emm_pkg::NIN*emm_pkg::EDID_BYTES];

  emm_pkg::emm_emu_cfg_t emu_cfg_reg [emm_pkg::NIN];
  emm_pkg::emm_out_cfg_t out_cfg_reg [emm_pkg::NOUT];
  logic [emm_pkg::MW-1:0] pool_addr_reg;
  logic [emm_pkg::MW-1:0] cap_addr_reg;
  logic [emm_pkg::NOUT-1:0] out_valid_reg;
  logic [emm_pkg::NIN-1:0] pend_reg;
  logic [emm_pkg::NIN-1:0] hpd_reg;
  logic [emm_pkg::HPD_CW-1:0] hpd_cnt_reg [emm_pkg::NIN];

  // ****************************************
  // Bus slave
  // ****************************************
  logic dph_wr_reg;
  logic [7:0] dph_ofs_reg;
  wire addr_ok = hsel && htrans[1] && hready;
  wire [7:0] a_ofs = haddr[7:0];
  wire [1:0] a_idx = haddr[3:2];
  wire [1:0] d_idx = dph_ofs_reg[3:2];
  wire wr_now = dph_wr_reg;
  wire wr_emu = wr_now && (dph_ofs_reg[7:4] == emm_pkg::EMU_CFG_OFS[7:4]);
  wire wr_out = wr_now && (dph_ofs_reg[7:4] == emm_pkg::OUT_CFG_OFS[7:4]);
  wire wr_pa = wr_now && (dph_ofs_reg == emm_pkg::POOL_ADDR_OFS);
  wire wr_pd = wr_now && (dph_ofs_reg == emm_pkg::POOL_DATA_OFS);
  wire wr_ca = wr_now && (dph_ofs_reg == emm_pkg::CAP_ADDR_OFS);
  wire rd_pd = addr_ok && !hwrite && (a_ofs == emm_pkg::POOL_DATA_OFS);
  wire engine_busy;
  wire [31:0] status_word = {19'h00000, engine_busy, pend_reg, out_valid_reg, hpd_reg};
  // Pool pointer as seen by a read overlapping a pool write's data phase
  wire [emm_pkg::MW-1:0] pool_cur = wr_pa ? hwdata[emm_pkg::MW-1:0]
                                          : pool_addr_reg + emm_pkg::MW'(wr_pd);

  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000;
    case (a_ofs)
      emm_pkg::STATUS_OFS: rd_word = status_word;
      emm_pkg::POOL_ADDR_OFS: rd_word = {22'h000000, pool_cur};
      emm_pkg::POOL_DATA_OFS: rd_word = {24'h000000, pool_mem[pool_cur]};
      emm_pkg::CAP_ADDR_OFS: rd_word = {22'h000000, cap_addr_reg};
      emm_pkg::CAP_DATA_OFS: rd_word = {24'h000000, out_mem[cap_addr_reg]};
      default: begin
        if (a_ofs[7:4] == emm_pkg::EMU_CFG_OFS[7:4]) begin
          rd_word = {28'h0000000, emu_cfg_reg[a_idx]};
        end else if (a_ofs[7:4] == emm_pkg::OUT_CFG_OFS[7:4]) begin
          rd_word = {29'h00000000, out_cfg_reg[a_idx]};
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_reg <= 1'b0;
      dph_ofs_reg <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dph_wr_reg <= addr_ok && hwrite;
      if (addr_ok) begin
        dph_ofs_reg <= a_ofs;
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < emm_pkg::NIN; i++) begin
        emu_cfg_reg[i] <= emm_pkg::EMU_CFG_RST;
      end
      for (int o = 0; o < emm_pkg::NOUT; o++) begin
        out_cfg_reg[o] <= emm_pkg::OUT_CFG_RST;
      end
    end else begin
      if (wr_emu) begin
        emu_cfg_reg[d_idx] <= hwdata[3:0];
      end
      if (wr_out) begin
        out_cfg_reg[d_idx] <= hwdata[2:0];
      end
    end
  end

  // Pool address auto-steps on each data access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pool_addr_reg <= '0;
      cap_addr_reg <= '0;
    end else begin
      if (wr_pa || wr_pd || rd_pd) begin
        pool_addr_reg <= pool_cur + emm_pkg::MW'(rd_pd);
      end
      if (wr_ca) begin
        cap_addr_reg <= hwdata[emm_pkg::MW-1:0];
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (wr_pd) begin
      pool_mem[pool_addr_reg] <= hwdata[7:0];
    end
  end

  // ****************************************
  // Sink capture
  // ****************************************
  wire cap_end = cap.valid && cap.last;
  wire cap_new_ok = cap_end && cap.good;

  always_ff @(posedge hclk) begin
    if (cap.valid) begin
      out_mem[mem_idx(cap.port, cap.addr)] <= cap.data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid_reg <= '0;
    end else if (cap_end) begin
      out_valid_reg[cap.port] <= cap.good;
    end
  end

  // ****************************************
  // Reload requests
  // ****************************************
  logic [emm_pkg::NIN-1:0] req_set;
  always_comb begin
    for (int i = 0; i < emm_pkg::NIN; i++) begin
      req_set[i] = (wr_emu && d_idx == i[1:0])
        || (cap_new_ok && emu_cfg_reg[i].dynamic && emu_cfg_reg[i].src == cap.port);
    end
  end

  logic [emm_pkg::PW-1:0] pick;
  logic pick_ok;
  always_comb begin
    pick = '0;
    pick_ok = 1'b0;
    for (int i = emm_pkg::NIN - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pick = i[emm_pkg::PW-1:0];
        pick_ok = 1'b1;
      end
    end
  end

  // ****************************************
  // Copy engine
  // ****************************************
  typedef enum logic {EMM_IDLE, EMM_COPY} emm_state_t;
  emm_state_t state_reg;
  logic [emm_pkg::PW-1:0] tgt_reg;
  logic [emm_pkg::BW-1:0] idx_reg;
  logic done_reg;
  wire start = (state_reg == EMM_IDLE) && pick_ok;
  wire last_byte = (idx_reg == emm_pkg::BW'(emm_pkg::EDID_BYTES - 1));
  wire emm_pkg::emm_emu_cfg_t tcfg = emu_cfg_reg[tgt_reg];
  wire [7:0] src_byte = tcfg.dynamic ? out_mem[mem_idx(tcfg.src, idx_reg)]
                                      : pool_mem[mem_idx(tcfg.src, idx_reg)];
  assign engine_busy = (state_reg == EMM_COPY);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= EMM_IDLE;
      tgt_reg <= '0;
      idx_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        EMM_IDLE: begin
          idx_reg <= '0;
          if (pick_ok) begin
            tgt_reg <= pick;
            state_reg <= EMM_COPY;
          end
        end
        EMM_COPY: begin
          idx_reg <= idx_reg + 1'b1;
          if (last_byte) begin
            done_reg <= 1'b1;
            state_reg <= EMM_IDLE;
          end
        end
        default: state_reg <= EMM_IDLE;
      endcase
    end
  end

  // Only the targeted input's storage is written
  always_ff @(posedge hclk) begin
    if (state_reg == EMM_COPY) begin
      in_mem[mem_idx(tgt_reg, idx_reg)] <= src_byte;
    end
  end

  // Set wins over the engine taking the request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= '0;
    end else begin
      for (int i = 0; i < emm_pkg::NIN; i++) begin
        if (req_set[i]) begin
          pend_reg[i] <= 1'b1;
        end else if (start && pick == i[emm_pkg::PW-1:0]) begin
          pend_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Hot-plug toggle and source side
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hpd_reg <= '0;
      for (int i = 0; i < emm_pkg::NIN; i++) begin
        hpd_cnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < emm_pkg::NIN; i++) begin
        if (done_reg && tgt_reg == i[emm_pkg::PW-1:0]) begin
          // Load edge itself is the first low cycle
          hpd_cnt_reg[i] <= emm_pkg::HPD_CW'(HPD_CYC - 1);
          hpd_reg[i] <= 1'b0;
        end else if (hpd_cnt_reg[i] != '0) begin
          hpd_cnt_reg[i] <= hpd_cnt_reg[i] - 1'b1;
          hpd_reg[i] <= 1'b0;
        end else begin
          hpd_reg[i] <= 1'b1;
        end
      end
    end
  end

  assign sink_presence_line = hpd_reg;

  // Source reads its own input's copy only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ddc_data <= '0;
      hdcp_capable <= '0;
    end else begin
      for (int i = 0; i < emm_pkg::NIN; i++) begin
        ddc_data[i*8 +: 8] <= in_mem[mem_idx(i[emm_pkg::PW-1:0], ddc_addr[i*8 +: 8])];
        hdcp_capable[i] <= emu_cfg_reg[i].hdcp_en;
      end
    end
  end

  // ****************************************
  // Output encryption policy
  // ****************************************
  logic [emm_pkg::NOUT-1:0] enc_next;
  logic [emm_pkg::NOUT-1:0] alert_next;
  always_comb begin
    for (int o = 0; o < emm_pkg::NOUT; o++) begin
      alert_next[o] = in_encrypted[out_cfg_reg[o].route] && !sink_hdcp_ok[o];
      enc_next[o] = sink_hdcp_ok[o]
        && (out_cfg_reg[o].enc_always || in_protected[out_cfg_reg[o].route]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_encrypt <= '0;
      out_alert <= '0;
      out_route <= '0;
    end else begin
      out_encrypt <= enc_next;
      out_alert <= alert_next;
      for (int o = 0; o < emm_pkg::NOUT; o++) begin
        out_route[o*2 +: 2] <= out_cfg_reg[o].route;
      end
    end
  end

endmodule : emm_port_manager

// [emm_src_model.sv]
// Video source model reading presented identification bytes
`timescale 1ns/1ps
module emm_src_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic present,
  input wire logic slow,
  output logic [7:0] ddc_addr
);
  logic step_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ddc_addr <= 8'h00;
      step_reg <= 1'b0;
    end else if (present) begin
      step_reg <= ~step_reg;
      if (!slow || step_reg) begin
        ddc_addr <= ddc_addr + 8'h01;
      end
    end else begin
      ddc_addr <= 8'h00;
    end
  end
endmodule : emm_src_model

// [emm_port_manager_asserts.sv]
// Concurrent checks on the port manager outputs
`timescale 1ns/1ps
module emm_port_manager_asserts #(
  parameter int HPD_CYC = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [3:0] sink_presence_line,
  input wire logic [3:0] in_encrypted,
  input wire logic [3:0] in_protected,
  input wire logic [3:0] sink_hdcp_ok,
  input wire logic [7:0] out_route,
  input wire logic [3:0] out_encrypt,
  input wire logic [3:0] out_alert
);
  logic [31:0] low_cnt;
  logic armed;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt <= 32'h0;
      armed <= 1'b0;
    end else begin
      low_cnt <= sink_presence_line[0] ? 32'h0 : low_cnt + 32'h1;
      armed <= armed | sink_presence_line[0];
    end
  end
  function automatic logic [3:0] sel(input logic [3:0] v, input logic [7:0] r);
    for (int o = 0; o < 4; o++) begin
      sel[o] = v[r[2*o+:2]];
    end
  endfunction : sel
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_bus_ready: assert property ($past(hresetn) |-> hreadyout)
    else $error("bus not ready");
  chk_bus_okay: assert property (!hresp)
    else $error("bus response not okay");
  chk_alert_policy: assert property ($past(hresetn) && $stable(out_route) |->
    out_alert == (sel($past(in_encrypted), out_route) & ~$past(sink_hdcp_ok)))
    else $error("alert flag wrong");
  chk_enc_needs_ok: assert property ($past(hresetn) |->
    (out_encrypt & ~$past(sink_hdcp_ok)) == 4'h0)
    else $error("encrypting toward non-compliant sink");
  chk_enc_protected: assert property ($past(hresetn) && $stable(out_route) |->
    (sel($past(in_protected), out_route) & $past(sink_hdcp_ok) & ~out_encrypt) == 4'h0)
    else $error("protected content sent plain");
  chk_alert_no_enc: assert property ((out_alert & out_encrypt) == 4'h0)
    else $error("alert and encrypt together");
  chk_hpd_length: assert property ($rose(sink_presence_line[0]) && armed |->
    low_cnt == HPD_CYC)
    else $error("hot-plug low interval wrong");
  chk_hpd_max: assert property (armed |-> low_cnt <= HPD_CYC)
    else $error("hot-plug low too long");
  cover property ($rose(sink_presence_line[0]) && armed);
  cover property (out_alert != 4'h0);
  cover property (out_encrypt != 4'h0);
endmodule : emm_port_manager_asserts
bind emm_port_manager emm_port_manager_asserts #(.HPD_CYC(HPD_CYC)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .sink_presence_line(sink_presence_line), .in_encrypted(in_encrypted),
  .in_protected(in_protected), .sink_hdcp_ok(sink_hdcp_ok), .out_route(out_route),
  .out_encrypt(out_encrypt), .out_alert(out_alert));

// [test_emm_port_manager.sv]
// Self-checking bench for the port manager
`timescale 1ns/1ps
module test_emm_port_manager;
  localparam int HPD = 20;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, ddc_data;
  logic [1:0] htrans = 0;
  logic [3:0] spl, cap_ok, in_enc = 0, in_prot = 0, ok = 0, o_enc, o_al, enc_al = 0, ea, ee;
  logic [7:0] src_addr, o_route, route = 0;
  logic [7:0] ref_mem [256];
  logic [15:0] seed = 16'h000f;
  emm_pkg::emm_cap_t cap = '0;
  int mismatches = 0, compares = 0;
  always #12.5 hclk = ~hclk;
  emm_port_manager #(.HPD_CYC(HPD)) i_emm_port_manager (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cap(cap), .ddc_addr({24'h0, src_addr}), .ddc_data(ddc_data),
    .sink_presence_line(spl), .hdcp_capable(cap_ok), .in_encrypted(in_enc),
    .in_protected(in_prot), .sink_hdcp_ok(ok), .out_route(o_route),
    .out_encrypt(o_enc), .out_alert(o_al));
  emm_src_model i_emm_src_model (.hclk(hclk), .hresetn(hresetn), .present(spl[0]),
    .slow(slow), .ddc_addr(src_addr));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    q = hrdata;
    if (n >= 50) begin
      mismatches++;
      results();
    end
  endtask : bus
  task automatic wait_line(input logic v);
    int n;
    n = 0;
    while (spl[0] !== v) begin
      @(posedge hclk);
      n++;
      if (n > 1000) begin
        mismatches++;
        results();
      end
    end
  endtask : wait_line
  task automatic fill;
    for (int b = 0; b < 256; b++) begin
      seed = lfsr(seed);
      ref_mem[b] = seed[7:0];
    end
  endtask : fill
  task automatic cap_send(input logic g);
    for (int b = 0; b < 256; b++) begin
      cap <= {1'b1, b == 255, g, 2'h1, b[7:0], ref_mem[b]};
      @(posedge hclk);
    end
    cap <= '0;
  endtask : cap_send
  task automatic ddc_check;
    logic [7:0] prev;
    wait_line(1'b0);
    chk("other line", 32'h1, spl[1]);
    wait_line(1'b1);
    @(posedge hclk);
    prev = src_addr;
    repeat (300) begin
      @(posedge hclk);
      chk("ddc byte", ref_mem[prev], ddc_data[7:0]);
      prev = src_addr;
    end
  endtask : ddc_check
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("lines", 32'hf, spl);
    chk("capable", 32'hf, cap_ok);
    bus(8'h40, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    fill();
    bus(8'h24, 1'b1, 32'h200);
    for (int b = 0; b < 256; b++) bus(8'h28, 1'b1, {24'h0, ref_mem[b]});
    bus(8'h24, 1'b1, 32'h205);
    bus(8'h28, 1'b0, 32'h0);
    chk("pool byte", ref_mem[5], q);
    bus(8'h00, 1'b1, 32'hc);
    ddc_check();
    fill();
    cap_send(1'b1);
    bus(8'h2c, 1'b1, 32'h109);
    bus(8'h30, 1'b0, 32'h0);
    chk("captured byte", ref_mem[9], q);
    bus(8'h00, 1'b1, 32'hb);
    ddc_check();
    fill();
    slow <= 1'b1;
    cap_send(1'b1);
    ddc_check();
    cap_send(1'b0);
    bus(8'h20, 1'b0, 32'h0);
    chk("status", 32'hf, q);
    repeat (300) begin
      @(posedge hclk);
      chk("no reload", 32'h1, spl[0]);
    end
    bus(8'h08, 1'b1, 32'h0);
    repeat (3) @(posedge hclk);
    chk("capable", 32'hb, cap_ok);
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      route[2*(k%4)+:2] = seed[1:0];
      enc_al[k%4] = seed[2];
      bus(8'h10 + 8'(4 * (k % 4)), 1'b1, {29'h0, seed[2:0]});
      in_enc <= seed[6:3];
      in_prot <= seed[10:7];
      ok <= seed[14:11];
      repeat (3) @(posedge hclk);
      for (int o = 0; o < 4; o++) begin
        ea[o] = in_enc[route[2*o+:2]] & ~ok[o];
        ee[o] = ok[o] & (enc_al[o] | in_prot[route[2*o+:2]]);
      end
      chk("alert", ea, o_al);
      chk("encrypt", ee, o_enc);
      chk("route", route, o_route);
    end
    results();
  end
endmodule : test_emm_port_manager
